// File: design/qbx_regs.svh
`ifndef QBX_REGS_SVH
`define QBX_REGS_SVH

// reserved general-call target and the only accepted reset byte
`define QBX_GCALL_ADDR  7'h00
`define QBX_SWRST_BYTE  8'h06

// output latch and pin snapshot value after any reset
`define QBX_LATCH_RST   8'hFF
`define QBX_SNAP_RST    16'hFFFF

// 7-bit address bases, indexed by {hi strap is SCL/SDA, lo is SCL/SDA}
`define QBX_BASE_PP     7'h24
`define QBX_BASE_PB     7'h2C
`define QBX_BASE_BP     7'h14
`define QBX_BASE_BB     7'h1C

// bit counter value of the acknowledge clock
`define QBX_ACK_BIT     4'h8
`define QBX_LAST_DBIT   4'h7

// master: core cycles per quarter of a serial clock period
`define QBX_QTR_CYC     5

`endif

// File: design/qbx_pkg.sv
package qbx_pkg;

    // strap level on an address-select pin
    typedef enum logic [1:0] {
        QBX_STRAP_GND = 2'b00,
        QBX_STRAP_VCC = 2'b01,
        QBX_STRAP_SCL = 2'b10,
        QBX_STRAP_SDA = 2'b11
    } qbx_strap_t;

    // device serial engine state
    typedef enum logic [2:0] {
        QBX_L_ADDR   = 3'b000,
        QBX_L_WRITE  = 3'b001,
        QBX_L_READ   = 3'b010,
        QBX_L_GCALL  = 3'b011,
        QBX_L_GDONE  = 3'b100,
        QBX_L_IGNORE = 3'b101
    } qbx_link_st_t;

    // master command
    typedef enum logic [1:0] {
        QBX_CMD_WRITE = 2'b00,
        QBX_CMD_READ  = 2'b01,
        QBX_CMD_GCALL = 2'b10
    } qbx_cmd_t;

    // master sequencer state
    typedef enum logic [1:0] {
        QBX_M_IDLE  = 2'b00,
        QBX_M_START = 2'b01,
        QBX_M_BITS  = 2'b10,
        QBX_M_STOP  = 2'b11
    } qbx_mst_st_t;

endpackage

// File: design/qbx_link_if.sv
`timescale 1ns/10ps
interface qbx_link_if;
    logic scl;
    logic m_sda_oe;
    logic d_sda_oe;
    logic d_int_oe;
    logic sda;
    logic int_n;

    // open-drain wires with pull-ups: low while any end pulls
    assign sda   = ~(m_sda_oe | d_sda_oe);
    assign int_n = ~d_int_oe;

    modport master (
        output scl,
        output m_sda_oe,
        input  sda,
        input  int_n
    );

    modport device (
        input  scl,
        input  sda,
        output d_sda_oe,
        output d_int_oe
    );
endinterface

// File: design/qbx_exp_device.sv
// Overview of operation
// - ack general call only with write direction
// - after general call ack only byte 06h
// - never ack bytes after the reset byte
// - stop after reset byte resets; restart does not
// - master treats any nack as aborted reset
// - byte pairs map to port 0 then 1
// - all output latches high at power-on
// - written-high pins get strong pull-up until fall
// - write byte drives pins after its ack
// - unlimited write bytes, each pair overwrites latches
// - read returns sampled pin levels
// - read may stop anytime; last ack data valid
// - master writes ones to pins used as inputs
// - power-on reset holds and initialises everything
// - interrupt on any port pin edge
// - interrupt released on pin restore or access
// - write strobe releases the interrupt
// - read capture strobe releases the interrupt
// - changes during clearing may be missed
// - hardware reset pin low holds defaults
// - master writes tied pins to equal values
// - address chosen by two four-level straps
`timescale 1ns/10ps
`include "qbx_regs.svh"
module qbx_exp_device
    import qbx_pkg::*;
(
    // core clock and resets
    input  wire logic       i_core_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_rst_pin_n,
    // address straps
    input  wire logic [1:0] i_addr_sel_lo,
    input  wire logic [1:0] i_addr_sel_hi,
    // port pins
    input  wire logic [7:0] i_port0_pins,
    input  wire logic [7:0] i_port1_pins,
    output logic      [7:0] o_port0_drive_low,
    output logic      [7:0] o_port1_drive_low,
    output logic      [7:0] o_port0_strong_pu,
    output logic      [7:0] o_port1_strong_pu,
    // serial link
    qbx_link_if.device      link
);

    function automatic logic [6:0] own_addr(input logic [1:0] hi,
                                            input logic [1:0] lo);
        logic [6:0] base;
        base = `QBX_BASE_PP;
        unique case ({hi[1], lo[1]})
            2'b00: base = `QBX_BASE_PP;
            2'b01: base = `QBX_BASE_PB;
            2'b10: base = `QBX_BASE_BP;
            2'b11: base = `QBX_BASE_BB;
        endcase
        return base | {5'h00, hi[0], lo[0]};
    endfunction

    // ---------------- core domain ----------------
    logic        core_rst_n;
    logic        scl_s1, scl_s2, sda_s1, sda_s2, sda_s3;
    logic        armed_reg, armed_s1, armed_s2;
    logic        ev_tgl_reg, ev_s1, ev_s2, ev_s3;
    logic [15:0] pins_s1, pins_s2;
    logic [15:0] snap_reg;
    logic        int_reg;
    logic        clr_reg;
    logic        swrst_reg;
    logic        start_det, stop_det;

    assign core_rst_n = i_reset_n & i_rst_pin_n;

    always_ff @(posedge i_core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            scl_s1   <= 1'b1;
            scl_s2   <= 1'b1;
            sda_s1   <= 1'b1;
            sda_s2   <= 1'b1;
            sda_s3   <= 1'b1;
            armed_s1 <= 1'b0;
            armed_s2 <= 1'b0;
            ev_s1    <= 1'b0;
            ev_s2    <= 1'b0;
            ev_s3    <= 1'b0;
            pins_s1  <= `QBX_SNAP_RST;
            pins_s2  <= `QBX_SNAP_RST;
        end else begin
            scl_s1   <= link.scl;
            scl_s2   <= scl_s1;
            sda_s1   <= link.sda;
            sda_s2   <= sda_s1;
            sda_s3   <= sda_s2;
            armed_s1 <= armed_reg;
            armed_s2 <= armed_s1;
            ev_s1    <= ev_tgl_reg;
            ev_s2    <= ev_s1;
            ev_s3    <= ev_s2;
            pins_s1  <= {i_port1_pins, i_port0_pins};
            pins_s2  <= pins_s1;
        end
    end

    assign start_det = scl_s2 & sda_s3 & ~sda_s2;
    assign stop_det  = scl_s2 & ~sda_s3 & sda_s2;

    // frame edges end the link-side frame even when scl stands still
    always_ff @(posedge i_core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            clr_reg   <= 1'b0;
            swrst_reg <= 1'b0;
        end else begin
            clr_reg   <= start_det | stop_det;
            swrst_reg <= stop_det & armed_s2;
        end
    end

    always_ff @(posedge i_core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            snap_reg <= `QBX_SNAP_RST;
            int_reg  <= 1'b0;
        end else if (swrst_reg) begin
            snap_reg <= `QBX_SNAP_RST;
            int_reg  <= 1'b0;
        end else if (ev_s2 ^ ev_s3) begin
            snap_reg <= pins_s2;
            int_reg  <= 1'b0;
        end else begin
            int_reg  <= |(pins_s2 ^ snap_reg);
        end
    end

    assign link.d_int_oe = int_reg;

    // ---------------- link domain ----------------
    logic         link_rst_n, frame_rst_n;
    logic [3:0]   strap_s1, strap_s2;
    logic [15:0]  lpin_s1, lpin_s2;
    qbx_link_st_t st_reg;
    logic [3:0]   cnt_reg;
    logic [7:0]   rx_reg, tx_reg, wr_byte_reg;
    logic         ack_go_reg, hdr_reg, sel_reg;
    logic         wr_pend_reg, wr_port_reg, sda_oe_reg;
    logic [7:0]   drv_low_reg [2];
    logic [7:0]   pu_reg [2];
    logic [7:0]   byte_in;
    logic         ack_clk, rd_capture, wr_strobe;

    assign link_rst_n  = core_rst_n & ~swrst_reg;
    assign frame_rst_n = link_rst_n & ~clr_reg;
    assign byte_in     = {rx_reg[6:0], link.sda};
    assign ack_clk     = (cnt_reg == `QBX_ACK_BIT);
    assign rd_capture  = ack_clk & (st_reg == QBX_L_READ)
                         & (hdr_reg | ~link.sda);
    assign wr_strobe   = ack_clk & (st_reg == QBX_L_WRITE) & ~hdr_reg;

    always_ff @(posedge link.scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            strap_s1 <= 4'h0;
            strap_s2 <= 4'h0;
            lpin_s1  <= `QBX_SNAP_RST;
            lpin_s2  <= `QBX_SNAP_RST;
        end else begin
            strap_s1 <= {i_addr_sel_hi, i_addr_sel_lo};
            strap_s2 <= strap_s1;
            lpin_s1  <= {i_port1_pins, i_port0_pins};
            lpin_s2  <= lpin_s1;
        end
    end

    always_ff @(posedge link.scl or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            st_reg      <= QBX_L_ADDR;
            cnt_reg     <= 4'h0;
            rx_reg      <= 8'h00;
            tx_reg      <= 8'hFF;
            wr_byte_reg <= 8'h00;
            ack_go_reg  <= 1'b0;
            hdr_reg     <= 1'b0;
            sel_reg     <= 1'b0;
            armed_reg   <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_port_reg <= 1'b0;
        end else if (!ack_clk) begin
            rx_reg      <= byte_in;
            cnt_reg     <= cnt_reg + 4'h1;
            wr_pend_reg <= 1'b0;
            if (cnt_reg == `QBX_LAST_DBIT) begin
                hdr_reg    <= (st_reg == QBX_L_ADDR);
                ack_go_reg <= 1'b0;
                unique case (st_reg)
                    QBX_L_ADDR: begin
                        if (byte_in[7:1] == own_addr(strap_s2[3:2],
                                                     strap_s2[1:0])) begin
                            ack_go_reg <= 1'b1;
                            st_reg     <= byte_in[0] ? QBX_L_READ
                                                     : QBX_L_WRITE;
                        end else if (byte_in == {`QBX_GCALL_ADDR, 1'b0}) begin
                            ack_go_reg <= 1'b1;
                            st_reg     <= QBX_L_GCALL;
                        end else begin
                            st_reg     <= QBX_L_IGNORE;
                        end
                    end
                    QBX_L_WRITE: begin
                        ack_go_reg  <= 1'b1;
                        wr_byte_reg <= byte_in;
                    end
                    QBX_L_GCALL: begin
                        if (byte_in == `QBX_SWRST_BYTE) begin
                            ack_go_reg <= 1'b1;
                            armed_reg  <= 1'b1;
                            st_reg     <= QBX_L_GDONE;
                        end else begin
                            st_reg     <= QBX_L_IGNORE;
                        end
                    end
                    QBX_L_GDONE: begin
                        armed_reg <= 1'b0;
                        st_reg    <= QBX_L_IGNORE;
                    end
                    QBX_L_READ, QBX_L_IGNORE: begin
                        ack_go_reg <= 1'b0;
                    end
                    default: st_reg <= QBX_L_IGNORE;
                endcase
            end
        end else begin
            cnt_reg <= 4'h0;
            hdr_reg <= 1'b0;
            if (wr_strobe) begin
                wr_pend_reg <= 1'b1;
                wr_port_reg <= sel_reg;
                sel_reg     <= ~sel_reg;
            end
            if (st_reg == QBX_L_READ) begin
                if (rd_capture) begin
                    tx_reg  <= sel_reg ? lpin_s2[15:8] : lpin_s2[7:0];
                    sel_reg <= ~sel_reg;
                end else begin
                    st_reg  <= QBX_L_IGNORE;
                end
            end
        end
    end

    // one toggle per write strobe or read capture feeds the snapshot
    always_ff @(posedge link.scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ev_tgl_reg <= 1'b0;
        end else if (wr_strobe | rd_capture) begin
            ev_tgl_reg <= ~ev_tgl_reg;
        end
    end

    always_ff @(negedge link.scl or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            sda_oe_reg <= 1'b0;
        end else begin
            sda_oe_reg <= (ack_clk & ack_go_reg)
                          | ((st_reg == QBX_L_READ) & ~ack_clk
                             & ~tx_reg[~cnt_reg[2:0]]);
        end
    end

    assign link.d_sda_oe = sda_oe_reg;

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            always_ff @(negedge link.scl or negedge link_rst_n) begin
                if (!link_rst_n) begin
                    drv_low_reg[p] <= ~`QBX_LATCH_RST;
                    pu_reg[p]      <= 8'h00;
                end else if (wr_pend_reg && (wr_port_reg == p[0])) begin
                    drv_low_reg[p] <= ~wr_byte_reg;
                    pu_reg[p]      <= wr_byte_reg;
                end else begin
                    pu_reg[p]      <= 8'h00;
                end
            end
        end
    endgenerate

    assign o_port0_drive_low = drv_low_reg[0];
    assign o_port1_drive_low = drv_low_reg[1];
    assign o_port0_strong_pu = pu_reg[0];
    assign o_port1_strong_pu = pu_reg[1];

endmodule

// File: design/qbx_exp_master.sv
`timescale 1ns/10ps
`include "qbx_regs.svh"
module qbx_exp_master
    import qbx_pkg::*;
#(
    parameter int QTR_CYC = `QBX_QTR_CYC
)(
    // core clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // command
    input  wire logic        i_req,
    input  wire qbx_cmd_t    i_cmd,
    input  wire logic [6:0]  i_addr7,
    input  wire logic [15:0] i_wdata,
    // status
    output logic             o_busy,
    output logic             o_done,
    output logic             o_nack,
    output logic      [15:0] o_rdata,
    output logic             o_irq,
    // serial link
    qbx_link_if.master       link
);

    // the device needs scl high for more than four core cycles
    if (QTR_CYC < 3 || QTR_CYC > 255) begin : g_bad_qtr
        $error("QTR_CYC out of range");
    end

    function automatic logic [8:0] load9(input qbx_cmd_t   cmd,
                                         input logic [1:0] idx,
                                         input logic [6:0] addr,
                                         input logic [15:0] wd);
        logic [8:0] v;
        v = 9'h1FF;
        unique case (cmd)
            QBX_CMD_GCALL: v = (idx == 2'h0) ? {`QBX_GCALL_ADDR, 2'b01}
                                             : {`QBX_SWRST_BYTE, 1'b1};
            QBX_CMD_WRITE: v = (idx == 2'h0) ? {addr, 2'b01}
                             : (idx == 2'h1) ? {wd[7:0], 1'b1}
                                             : {wd[15:8], 1'b1};
            QBX_CMD_READ:  v = (idx == 2'h0) ? {addr, 2'b11}
                             : (idx == 2'h1) ? 9'h1FE : 9'h1FF;
            default:       v = 9'h1FF;
        endcase
        return v;
    endfunction

    qbx_mst_st_t st_reg;
    qbx_cmd_t    cmd_reg;
    logic [7:0]  div_reg;
    logic        tick;
    logic [1:0]  ph_reg, idx_reg;
    logic [3:0]  bit_reg;
    logic [8:0]  tx_reg;
    logic [7:0]  rx_reg;
    logic [6:0]  addr_reg;
    logic [15:0] wdata_reg, rdata_reg;
    logic        scl_reg, sda_oe_reg, busy_reg, done_reg, nack_reg;
    logic        sda_s1, sda_s2, int_s1, int_s2, irq_reg;
    logic        last_byte, is_tx;

    assign tick      = (div_reg == 8'(QTR_CYC - 1));
    assign last_byte = (idx_reg == ((cmd_reg == QBX_CMD_GCALL) ? 2'h1
                                                                : 2'h2));
    assign is_tx     = (cmd_reg != QBX_CMD_READ) | (idx_reg == 2'h0);

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_reg <= 8'h00;
            sda_s1  <= 1'b1;
            sda_s2  <= 1'b1;
            int_s1  <= 1'b1;
            int_s2  <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            sda_s1  <= link.sda;
            sda_s2  <= sda_s1;
            int_s1  <= link.int_n;
            int_s2  <= int_s1;
            irq_reg <= ~int_s2;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_reg     <= QBX_M_IDLE;
            cmd_reg    <= QBX_CMD_WRITE;
            ph_reg     <= 2'h0;
            idx_reg    <= 2'h0;
            bit_reg    <= 4'h0;
            tx_reg     <= 9'h1FF;
            rx_reg     <= 8'h00;
            addr_reg   <= 7'h00;
            wdata_reg  <= 16'h0000;
            rdata_reg  <= 16'h0000;
            scl_reg    <= 1'b1;
            sda_oe_reg <= 1'b0;
            busy_reg   <= 1'b0;
            done_reg   <= 1'b0;
            nack_reg   <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            unique case (st_reg)
                QBX_M_IDLE: begin
                    if (i_req) begin
                        cmd_reg   <= i_cmd;
                        addr_reg  <= i_addr7;
                        wdata_reg <= i_wdata;
                        nack_reg  <= 1'b0;
                        busy_reg  <= 1'b1;
                        ph_reg    <= 2'h0;
                        st_reg    <= QBX_M_START;
                    end
                end
                QBX_M_START: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    if (ph_reg == 2'h0) sda_oe_reg <= 1'b1;
                    if (ph_reg == 2'h2) scl_reg <= 1'b0;
                    if (ph_reg == 2'h3) begin
                        idx_reg <= 2'h0;
                        bit_reg <= 4'h0;
                        tx_reg  <= load9(cmd_reg, 2'h0, addr_reg, wdata_reg);
                        st_reg  <= QBX_M_BITS;
                    end
                end
                QBX_M_BITS: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    unique case (ph_reg)
                        2'h0: sda_oe_reg <= ~tx_reg[8];
                        2'h1: scl_reg <= 1'b1;
                        2'h2: begin
                            if (bit_reg != `QBX_ACK_BIT)
                                rx_reg <= {rx_reg[6:0], sda_s2};
                            else if (is_tx && sda_s2)
                                nack_reg <= 1'b1;
                        end
                        2'h3: begin
                            scl_reg <= 1'b0;
                            if (bit_reg != `QBX_ACK_BIT) begin
                                bit_reg <= bit_reg + 4'h1;
                                tx_reg  <= {tx_reg[7:0], 1'b1};
                            end else begin
                                if (!is_tx && idx_reg == 2'h1)
                                    rdata_reg[7:0] <= rx_reg;
                                if (!is_tx && idx_reg == 2'h2)
                                    rdata_reg[15:8] <= rx_reg;
                                bit_reg <= 4'h0;
                                idx_reg <= idx_reg + 2'h1;
                                tx_reg  <= load9(cmd_reg, idx_reg + 2'h1,
                                                 addr_reg, wdata_reg);
                                if (nack_reg || last_byte)
                                    st_reg <= QBX_M_STOP;
                            end
                        end
                    endcase
                end
                QBX_M_STOP: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    if (ph_reg == 2'h0) sda_oe_reg <= 1'b1;
                    if (ph_reg == 2'h1) scl_reg <= 1'b1;
                    if (ph_reg == 2'h2) sda_oe_reg <= 1'b0;
                    if (ph_reg == 2'h3) begin
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                        st_reg   <= QBX_M_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.scl      = scl_reg;
    assign link.m_sda_oe = sda_oe_reg;
    assign o_busy        = busy_reg;
    assign o_done        = done_reg;
    assign o_nack        = nack_reg;
    assign o_rdata       = rdata_reg;
    assign o_irq         = irq_reg;

endmodule

// File: tb/qbx_link_props.sv
`timescale 1ns/10ps
module qbx_link_props #(
    parameter logic [6:0] DEV_ADDR = 7'h26
)(
    // clocks and resets
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_rst_pin_n,
    // link wires
    input wire logic scl,
    input wire logic m_sda_oe,
    input wire logic d_sda_oe,
    input wire logic d_int_oe,
    input wire logic sda,
    input wire logic int_n
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] nbit;
    logic [1:0] nbyte;
    logic [7:0] shreg;
    logic [7:0] first;
    logic       ack;

    // ninth scl rise of a byte
    assign ack = scl & ~scl_q & (nbit == 4'h8);

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            nbit  <= 4'h0;
            nbyte <= 2'h0;
            shreg <= 8'h00;
            first <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda != sda_q) begin
                nbit  <= 4'h0;
                nbyte <= 2'h0;
            end else if (ack) begin
                nbit  <= 4'h0;
                nbyte <= nbyte + {1'b0, nbyte != 2'h3};
                if (nbyte == 2'h0)
                    first <= shreg;
            end else if (scl && !scl_q) begin
                shreg <= {shreg[6:0], sda};
                nbit  <= nbit + 4'h1;
            end
        end
    end

    a_ack_when_low:
        assert property ($rose(d_sda_oe) |-> !scl)
        else $error("device pulled sda while scl high");
    a_gc_rd_nack:
        assert property (ack && nbyte == 2'h0 && shreg == 8'h01 |-> !d_sda_oe)
        else $error("general call read was acked");
    a_gc_wr_ack:
        assert property (ack && nbyte == 2'h0 && shreg == 8'h00 |-> d_sda_oe)
        else $error("general call write not acked");
    a_rst_byte_ack:
        assert property (ack && nbyte == 2'h1 && first == 8'h00
            |-> d_sda_oe == (shreg == 8'h06))
        else $error("reset byte ack wrong");
    a_extra_nack:
        assert property (ack && nbyte[1] && first == 8'h00 |-> !d_sda_oe)
        else $error("byte after reset byte acked");
    a_foreign_nack:
        assert property (ack && nbyte == 2'h0 && shreg[7:1] != DEV_ADDR
            && shreg[7:1] != 7'h00 |-> !d_sda_oe)
        else $error("foreign address acked");
    a_int_rd_clear:
        assert property (ack && d_int_oe && !sda
            && (nbyte == 2'h0 ? shreg : first) == {DEV_ADDR, 1'b1}
            |-> ##[1:8] !d_int_oe)
        else $error("read capture kept interrupt");
    a_int_wr_clear:
        assert property (ack && d_int_oe && nbyte != 2'h0
            && first == {DEV_ADDR, 1'b0} |-> ##[1:24] !d_int_oe)
        else $error("write strobe kept interrupt");
    a_pin_rst_quiet:
        assert property (!i_rst_pin_n |-> !d_sda_oe && !d_int_oe)
        else $error("outputs active during reset pin");
    a_por_quiet:
        assert property ($rose(i_reset_n) |-> !d_int_oe && !d_sda_oe)
        else $error("outputs active after reset");
endmodule

// File: tb/qbx_exp_bench.sv
`timescale 1ns/10ps
`include "qbx_regs.svh"
module qbx_exp_bench
    import qbx_pkg::*;
;
    // straps: hi at supply, lo at ground
    localparam logic [6:0] ADDR = `QBX_BASE_PP | 7'h02;
    logic        core_clk;
    logic        reset_n;
    logic        rst_pin_n;
    logic        req;
    qbx_cmd_t    cmd;
    logic [6:0]  addr7;
    logic [15:0] wdata;
    logic [15:0] ext;
    logic        busy;
    logic        done;
    logic        nack;
    logic        irq;
    logic [15:0] rdata;
    logic [7:0]  drv0;
    logic [7:0]  drv1;
    logic [7:0]  pu0;
    logic [7:0]  pu1;
    logic [15:0] pu_seen;
    int          bad_count;
    int          checked;

    qbx_link_if qbx_link_if_inst ();

    qbx_exp_device qbx_exp_device_inst (
        .i_core_clk        (core_clk),
        .i_reset_n         (reset_n),
        .i_rst_pin_n       (rst_pin_n),
        .i_addr_sel_lo     (QBX_STRAP_GND),
        .i_addr_sel_hi     (QBX_STRAP_VCC),
        .i_port0_pins      (ext[7:0]),
        .i_port1_pins      (ext[15:8]),
        .o_port0_drive_low (drv0),
        .o_port1_drive_low (drv1),
        .o_port0_strong_pu (pu0),
        .o_port1_strong_pu (pu1),
        .link              (qbx_link_if_inst.device)
    );

    qbx_exp_master qbx_exp_master_inst (
        .i_core_clk (core_clk),
        .i_reset_n  (reset_n),
        .i_req      (req),
        .i_cmd      (cmd),
        .i_addr7    (addr7),
        .i_wdata    (wdata),
        .o_busy     (busy),
        .o_done     (done),
        .o_nack     (nack),
        .o_rdata    (rdata),
        .o_irq      (irq),
        .link       (qbx_link_if_inst.master)
    );

    qbx_link_props #(.DEV_ADDR(ADDR)) qbx_link_props_inst (
        .i_core_clk  (core_clk),
        .i_reset_n   (reset_n),
        .i_rst_pin_n (rst_pin_n),
        .scl         (qbx_link_if_inst.scl),
        .m_sda_oe    (qbx_link_if_inst.m_sda_oe),
        .d_sda_oe    (qbx_link_if_inst.d_sda_oe),
        .d_int_oe    (qbx_link_if_inst.d_int_oe),
        .sda         (qbx_link_if_inst.sda),
        .int_n       (qbx_link_if_inst.int_n)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // strong pull-ups seen since the last request
    always @(posedge core_clk) begin
        if (req)
            pu_seen <= 16'h0000;
        else
            pu_seen <= pu_seen | {pu1, pu0};
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic run(input qbx_cmd_t c, input logic [6:0] a,
                       input logic [15:0] d, input logic exp_nack);
        int n;
        idle(1);
        cmd   = c;
        addr7 = a;
        wdata = d;
        req   = 1'b1;
        idle(1);
        req = 1'b0;
        n   = 0;
        while (done !== 1'b1 && n < 4000) begin
            idle(1);
            n++;
        end
        check("status", {13'h0, busy, done, nack}, {15'h1, exp_nack});
    endtask

    task automatic complete_run();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge core_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        reset_n   = 1'b0;
        rst_pin_n = 1'b1;
        req       = 1'b0;
        cmd       = QBX_CMD_WRITE;
        addr7     = 7'h00;
        wdata     = 16'h0000;
        ext       = 16'hFFFF;
        bad_count = 0;
        checked   = 0;
        idle(20);
        reset_n = 1'b1;
        check("drive", {drv1, drv0}, 16'h0000);
        check("pullup", {pu1, pu0}, 16'h0000);
        run(QBX_CMD_WRITE, ADDR, 16'hA55A, 1'b0);
        check("drive", {drv1, drv0}, 16'h5AA5);
        check("pu_seen", pu_seen, 16'hA55A);
        run(QBX_CMD_WRITE, ADDR, 16'hFFFF, 1'b0);
        check("drive", {drv1, drv0}, 16'h0000);
        ext = 16'h5AC3;
        idle(30);
        check("irq", 16'(irq), 16'h0001);
        run(QBX_CMD_READ, ADDR, 16'h0000, 1'b0);
        check("rdata", rdata, 16'h5AC3);
        idle(30);
        check("irq", 16'(irq), 16'h0000);
        ext = 16'h5AC2;
        idle(30);
        check("irq", 16'(irq), 16'h0001);
        ext = 16'h5AC3;
        idle(30);
        check("irq", 16'(irq), 16'h0000);
        ext = 16'h5A43;
        idle(30);
        run(QBX_CMD_WRITE, ADDR, 16'hFFFF, 1'b0);
        idle(30);
        check("irq", 16'(irq), 16'h0000);
        run(QBX_CMD_WRITE, ADDR ^ 7'h01, 16'h0000, 1'b1);
        run(QBX_CMD_WRITE, ADDR, 16'h00F0, 1'b0);
        run(QBX_CMD_READ, 7'h00, 16'h0000, 1'b1);
        run(QBX_CMD_WRITE, 7'h00, 16'h0005, 1'b1);
        check("drive", {drv1, drv0}, 16'hFF0F);
        run(QBX_CMD_WRITE, 7'h00, 16'h0106, 1'b1);
        check("drive", {drv1, drv0}, 16'hFF0F);
        run(QBX_CMD_GCALL, 7'h00, 16'h0000, 1'b0);
        idle(10);
        check("drive", {drv1, drv0}, 16'h0000);
        run(QBX_CMD_WRITE, ADDR, 16'h0000, 1'b0);
        rst_pin_n = 1'b0;
        idle(3);
        check("drive", {drv1, drv0}, 16'h0000);
        rst_pin_n = 1'b1;
        run(QBX_CMD_WRITE, ADDR, 16'h00FF, 1'b0);
        check("drive", {drv1, drv0}, 16'hFF00);
        complete_run();
    end
endmodule
